// file: rtl/bsp_defs.svh
// constants for the two-word burst data and load port
`ifndef BSP_DEFS_SVH
`define BSP_DEFS_SVH
`define BSP_DATA_W 36
`define BSP_LANE_W 9
`define BSP_LANES 4
`define BSP_ADDR_W 3
`define BSP_IDX_W 4
`define BSP_WORDS 16
`define BSP_BURST_LEN 2
`define BSP_BUF_DEPTH 2
`define BSP_SYNC_W 53
`define BSP_SYNC_RST 53'h10_0000_0000_0000
`define BSP_MASK_X8 36'h0_0000_00ff
`define BSP_MASK_X9 36'h0_0000_01ff
`define BSP_MASK_X18 36'h0_0003_ffff
`define BSP_MASK_X36 36'hf_ffff_ffff
`define BSP_LAUNCH_WAIT 40
`endif

// file: rtl/bsp_pkg.sv
// types of the two-word burst data and load port
package bsp_pkg;
    typedef enum logic [1:0] {
        BSP_X8 = 2'h0,
        BSP_X9 = 2'h1,
        BSP_X18 = 2'h2,
        BSP_X36 = 2'h3
    } bsp_width_e;
    typedef enum logic [1:0] {
        BSP_RD_IDLE = 2'h0,
        BSP_RD_FIRST = 2'h1,
        BSP_RD_HOLD = 2'h2
    } bsp_rd_e;
endpackage

// file: rtl/bsp_pair_buf.sv
// two-entry valid/ready buffer
`timescale 1ns/1ns
`include "bsp_defs.svh"
module bsp_pair_buf #(
    parameter int W = 8
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    logic [W-1:0] mem_q [`BSP_BUF_DEPTH];
    logic [W-1:0] mem_d [`BSP_BUF_DEPTH];
    logic wptr_q, wptr_d, rptr_q, rptr_d, ready_q, ready_d;
    logic [1:0] cnt_q, cnt_d;
    logic push, pop;

    assign out_valid_o = (cnt_q != 2'h0);
    assign out_data_o = mem_q[rptr_q];
    assign in_ready_o = ready_q;

    always_comb begin
        mem_d = mem_q;
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        cnt_d = cnt_q;
        pop = out_valid_o && out_ready_i;
        push = in_valid_i && ready_q;
        if (push) begin
            mem_d[wptr_q] = in_data_i;
            wptr_d = ~wptr_q;
        end
        if (pop) begin
            rptr_d = ~rptr_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'h1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'h1;
        end
        ready_d = (cnt_d != 2'h2);
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < `BSP_BUF_DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wptr_q <= 1'b0;
            rptr_q <= 1'b0;
            cnt_q <= 2'h0;
            ready_q <= 1'b1;
        end else begin
            mem_q <= mem_d;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end
endmodule

// file: rtl/bsp_port.sv
// data and load port of a two-word burst ddr sram
`timescale 1ns/1ns
`include "bsp_defs.svh"
module bsp_port (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic main_input_timing_pos_i,
    input wire logic main_input_timing_neg_i,
    input wire logic output_timing_pos_i,
    input wire logic output_timing_neg_i,
    input wire logic single_clock_mode_i,
    input wire logic [1:0] width_sel_i,
    input wire logic load_n_i,
    input wire logic access_dir_i,
    input wire logic [`BSP_ADDR_W-1:0] word_addr_i,
    input wire logic burst_lsb_addr_i,
    input wire logic [`BSP_LANES-1:0] byte_lane_write_sel_n_i,
    input wire logic [`BSP_DATA_W-1:0] data_pins_i,
    output logic [`BSP_DATA_W-1:0] data_pins_o,
    output logic data_pins_oe_o,
    input wire logic drain_stall_i,
    output logic wr_buf_ready_o
);
    localparam int BW = `BSP_IDX_W + 2 * `BSP_DATA_W;

    function automatic logic [`BSP_DATA_W-1:0] width_mask(input logic [1:0] w);
        case (w)
            bsp_pkg::BSP_X8: width_mask = `BSP_MASK_X8;
            bsp_pkg::BSP_X9: width_mask = `BSP_MASK_X9;
            bsp_pkg::BSP_X18: width_mask = `BSP_MASK_X18;
            default: width_mask = `BSP_MASK_X36;
        endcase
    endfunction

    function automatic logic [`BSP_DATA_W-1:0] lane_mask(input logic [1:0] w,
                                                        input logic [`BSP_LANES-1:0] sel_n);
        logic [`BSP_DATA_W-1:0] m;
        m = '0;
        for (int i = 0; i < `BSP_LANES; i++) begin
            m[i*`BSP_LANE_W +: `BSP_LANE_W] = {`BSP_LANE_W{~sel_n[i]}};
        end
        lane_mask = m & width_mask(w);
    endfunction

    // two-stage input synchronisers; clocks keep a third stage for edges
    logic [`BSP_SYNC_W-1:0] sync1_q, sync2_q, sync_d;
    logic [3:0] clk3_q;
    assign sync_d = {load_n_i, main_input_timing_pos_i, main_input_timing_neg_i,
                     output_timing_pos_i, output_timing_neg_i, access_dir_i,
                     burst_lsb_addr_i, byte_lane_write_sel_n_i, data_pins_i,
                     single_clock_mode_i, width_sel_i, word_addr_i};

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            sync1_q <= `BSP_SYNC_RST;
            sync2_q <= `BSP_SYNC_RST;
            clk3_q <= 4'h0;
        end else begin
            sync1_q <= sync_d;
            sync2_q <= sync1_q;
            clk3_q <= sync2_q[51:48];
        end
    end

    logic ld_n, dir, lsb, single;
    logic [3:0] clks, rise;
    logic [`BSP_LANES-1:0] sel_n;
    logic [`BSP_DATA_W-1:0] din, wmask;
    logic [1:0] width;
    logic [`BSP_ADDR_W-1:0] addr;
    logic k_rise, kn_rise, pos_rise, neg_rise, wide;
    logic [`BSP_IDX_W-1:0] start_idx;
    assign {ld_n, clks, dir, lsb, sel_n, din, single, width, addr} = sync2_q;
    assign rise = clks & ~clk3_q;
    assign k_rise = rise[3];
    assign kn_rise = rise[2];
    assign pos_rise = single ? rise[3] : rise[1];
    assign neg_rise = single ? rise[2] : rise[0];
    assign wide = (width == bsp_pkg::BSP_X18) || (width == bsp_pkg::BSP_X36);
    assign start_idx = {addr, wide ? lsb : 1'b0};
    assign wmask = width_mask(width);

    logic [`BSP_DATA_W-1:0] mem_q [`BSP_WORDS];
    logic [`BSP_DATA_W-1:0] mem_d [`BSP_WORDS];
    logic buf_in_valid, buf_in_ready, buf_out_valid;
    logic [`BSP_IDX_W-1:0] buf_in_idx, buf_out_idx;
    logic [`BSP_DATA_W-1:0] buf_out_data, buf_out_mask;
    logic wr_arm_q, wr_arm_d, wr_sec_q, wr_sec_d, rd_arm_q, rd_arm_d;
    logic [`BSP_IDX_W-1:0] wr_arm_idx_q, wr_arm_idx_d, wr_sec_idx_q, wr_sec_idx_d;
    logic [`BSP_IDX_W-1:0] rd_arm_idx_q, rd_arm_idx_d, rd_idx_q, rd_idx_d;
    bsp_pkg::bsp_rd_e rd_state_q, rd_state_d;
    logic [`BSP_DATA_W-1:0] dout_q, dout_d;
    logic oe_q, oe_d;

    bsp_pair_buf #(
        .W(BW)
    ) u_buf (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(buf_in_valid),
        .in_ready_o(buf_in_ready),
        .in_data_i({buf_in_idx, din & wmask, lane_mask(width, sel_n)}),
        .out_valid_o(buf_out_valid),
        .out_ready_i(!drain_stall_i),
        .out_data_o({buf_out_idx, buf_out_data, buf_out_mask})
    );

    // load, write capture and read launch
    always_comb begin
        wr_arm_d = wr_arm_q;
        wr_arm_idx_d = wr_arm_idx_q;
        wr_sec_d = wr_sec_q;
        wr_sec_idx_d = wr_sec_idx_q;
        rd_arm_d = rd_arm_q;
        rd_arm_idx_d = rd_arm_idx_q;
        rd_idx_d = rd_idx_q;
        rd_state_d = rd_state_q;
        dout_d = dout_q;
        oe_d = oe_q;
        buf_in_valid = 1'b0;
        buf_in_idx = wr_arm_idx_q;
        case (rd_state_q)
            bsp_pkg::BSP_RD_IDLE, bsp_pkg::BSP_RD_HOLD: begin
                if (pos_rise) begin
                    if (rd_arm_q) begin
                        dout_d = mem_q[rd_arm_idx_q] & wmask;
                        oe_d = 1'b1;
                        rd_idx_d = rd_arm_idx_q ^ 4'h1;
                        rd_arm_d = 1'b0;
                        rd_state_d = bsp_pkg::BSP_RD_FIRST;
                    end else begin
                        oe_d = 1'b0;
                        rd_state_d = bsp_pkg::BSP_RD_IDLE;
                    end
                end
            end
            bsp_pkg::BSP_RD_FIRST: begin
                if (neg_rise) begin
                    dout_d = mem_q[rd_idx_q] & wmask;
                    rd_state_d = bsp_pkg::BSP_RD_HOLD;
                end
            end
            default: begin
                oe_d = 1'b0;
                rd_state_d = bsp_pkg::BSP_RD_IDLE;
            end
        endcase
        // second-word push first, so a new second word set in the same cycle wins
        if (kn_rise && wr_sec_q) begin
            buf_in_valid = 1'b1;
            buf_in_idx = wr_sec_idx_q;
            wr_sec_d = 1'b0;
        end
        if (k_rise) begin
            if (wr_arm_q) begin
                buf_in_valid = 1'b1;
                buf_in_idx = wr_arm_idx_q;
                wr_sec_d = 1'b1;
                wr_sec_idx_d = wr_arm_idx_q ^ 4'h1;
            end
            wr_arm_d = 1'b0;
            if (!ld_n) begin
                if (dir) begin
                    rd_arm_d = 1'b1;
                    rd_arm_idx_d = start_idx;
                end else begin
                    wr_arm_d = 1'b1;
                    wr_arm_idx_d = start_idx;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            wr_arm_q <= 1'b0;
            wr_arm_idx_q <= 4'h0;
            wr_sec_q <= 1'b0;
            wr_sec_idx_q <= 4'h0;
            rd_arm_q <= 1'b0;
            rd_arm_idx_q <= 4'h0;
            rd_idx_q <= 4'h0;
            rd_state_q <= bsp_pkg::BSP_RD_IDLE;
            dout_q <= '0;
            oe_q <= 1'b0;
        end else begin
            wr_arm_q <= wr_arm_d;
            wr_arm_idx_q <= wr_arm_idx_d;
            wr_sec_q <= wr_sec_d;
            wr_sec_idx_q <= wr_sec_idx_d;
            rd_arm_q <= rd_arm_d;
            rd_arm_idx_q <= rd_arm_idx_d;
            rd_idx_q <= rd_idx_d;
            rd_state_q <= rd_state_d;
            dout_q <= dout_d;
            oe_q <= oe_d;
        end
    end

    // byte-lane merge into the word store
    always_comb begin
        mem_d = mem_q;
        if (buf_out_valid && !drain_stall_i) begin
            mem_d[buf_out_idx] = (mem_q[buf_out_idx] & ~buf_out_mask) |
                                 (buf_out_data & buf_out_mask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < `BSP_WORDS; i++) begin
                mem_q[i] <= '0;
            end
        end else begin
            mem_q <= mem_d;
        end
    end

    assign data_pins_o = dout_q;
    assign data_pins_oe_o = oe_q;
    assign wr_buf_ready_o = buf_in_ready;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (sys_rst_i);

    localparam int launch_wait = `BSP_LAUNCH_WAIT;

    idle_floats_a: assert property (rd_state_q == bsp_pkg::BSP_RD_IDLE |-> !data_pins_oe_o)
        else $error("pins driven while no read active");
    first_word_a: assert property (pos_rise && rd_arm_q && rd_state_q != bsp_pkg::BSP_RD_FIRST
        |=> data_pins_oe_o && data_pins_o == ($past(mem_q[rd_arm_idx_q]) & $past(wmask)))
        else $error("first read word wrong");
    second_word_a: assert property (rd_state_q == bsp_pkg::BSP_RD_FIRST && neg_rise
        |=> rd_state_q == bsp_pkg::BSP_RD_HOLD && data_pins_oe_o)
        else $error("second read word not launched");
    read_appears_a: assert property (k_rise && !ld_n && dir |-> ##[1:launch_wait] data_pins_oe_o)
        else $error("read not launched in time");
    single_mode_a: assert property (single && k_rise && rd_arm_q
        && rd_state_q != bsp_pkg::BSP_RD_FIRST |=> data_pins_oe_o)
        else $error("single clock mode launch missed");
    write_first_a: assert property (k_rise && wr_arm_q |-> buf_in_valid ##1 wr_sec_q)
        else $error("first write word not captured");
    write_second_a: assert property (kn_rise && wr_sec_q |-> buf_in_valid ##1 !wr_sec_q)
        else $error("second write word not captured");
    load_ignored_a: assert property (k_rise && ld_n |=> !wr_arm_q)
        else $error("write started without load");
    burst_next_a: assert property (k_rise && wr_arm_q
        |=> wr_sec_idx_q == ($past(wr_arm_idx_q) ^ 4'h1))
        else $error("burst counter did not advance");
    narrow_zero_a: assert property (k_rise && !ld_n && !wide
        |=> ($past(dir) ? !rd_arm_idx_q[0] : !wr_arm_idx_q[0]))
        else $error("narrow burst did not start at zero");
    lane_keep_a: assert property (buf_out_valid && !drain_stall_i
        |=> (mem_q[$past(buf_out_idx)] & ~$past(buf_out_mask))
            == ($past(mem_q[buf_out_idx]) & ~$past(buf_out_mask)))
        else $error("deselected lane changed");

    rd_burst_c: cover property (rd_state_q == bsp_pkg::BSP_RD_FIRST ##[1:20]
        rd_state_q == bsp_pkg::BSP_RD_HOLD);
    wr_burst_c: cover property (k_rise && wr_arm_q ##[1:20] kn_rise && wr_sec_q);
    buf_full_c: cover property (!wr_buf_ready_o);
    single_rd_c: cover property (single && data_pins_oe_o);
endmodule

// file: bench/bsp_ctrl_model.sv
// memory controller model on the link side of the burst port
`timescale 1ns/1ns
module bsp_ctrl_model (
    input wire logic clk_i,
    input wire logic single_i,
    input wire logic [35:0] dq_i,
    output logic k_o,
    output logic kb_o,
    output logic c_o,
    output logic cb_o,
    output logic load_n_o,
    output logic dir_o,
    output logic [2:0] addr_o,
    output logic bl_o,
    output logic [3:0] sel_n_o,
    output logic [35:0] dq_o,
    output logic dq_oe_o
);
    assign kb_o = ~k_o;
    // output clocks parked high in single clock mode
    assign c_o = single_i | k_o;
    assign cb_o = single_i | kb_o;
    initial begin
        {load_n_o, dir_o, addr_o, bl_o, sel_n_o, dq_o, dq_oe_o} = {1'b1, 9'h0, 36'h0, 1'b0};
        k_o = 1'b0;
        #3;
        forever #40 k_o = ~k_o;
    end
    // one load, two words; read words sampled on the wire
    task automatic xfer(input logic rd, input logic [2:0] a, input logic b,
        input logic [35:0] w0, input logic [35:0] w1, input logic [3:0] s0,
        input logic [3:0] s1, output logic [35:0] r0, output logic [35:0] r1);
        @(posedge kb_o);
        @(negedge clk_i);
        {load_n_o, dir_o, addr_o, bl_o} = {1'b0, rd, a, b};
        {dq_o, sel_n_o, dq_oe_o} = {w0, s0, ~rd};
        @(posedge kb_o);
        @(negedge clk_i);
        // load high: stale direction and address must be ignored
        {load_n_o, dir_o, addr_o} = {1'b1, ~rd, ~a};
        @(posedge k_o);
        repeat (2) @(negedge clk_i);
        {dq_o, sel_n_o} = {w1, s1};
        repeat (3) @(negedge clk_i);
        r0 = dq_i;
        // second read word stands from a few clk after the k-bar rise
        repeat (3) @(negedge clk_i);
        r1 = dq_i;
        {dq_o, dq_oe_o} = {~w1, 1'b0};
    endtask
endmodule

// file: bench/tb_burst2_sram_data_load_port.sv
// self-checking bench of the burst port against the controller model
`timescale 1ns/1ns
module tb_burst2_sram_data_load_port;
    localparam logic [35:0] W0 = 36'h1_2345_6789;
    localparam logic [35:0] W1 = 36'h9_8765_4321;
    localparam logic [35:0] LM = 36'h0_07fc_01ff;
    localparam logic [35:0] E0 = (36'ha_aaaa_aaaa & LM) | (W0 & ~LM);
    localparam logic [35:0] E1 = (36'h5_5555_5555 & ~LM) | (W1 & LM);
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic single = 1'b0;
    logic [1:0] width = 2'h3;
    logic stall = 1'b0;
    logic [3:0] cyc = 4'h0;
    logic k, kb, c, cb, load_n, dir, bl, ctl_oe, dut_oe, rdy;
    logic [2:0] addr;
    logic [3:0] sel_n;
    logic [35:0] ctl_dq, dut_dq, dq;
    int n_fail = 0;
    int cmp_count = 0;
    initial forever #5 clk = ~clk;
    always @(negedge clk) cyc <= cyc + 4'h1;
    // undriven wire shows a moving pattern
    assign dq = dut_oe ? dut_dq : (ctl_oe ? ctl_dq : {9{cyc}});
    bsp_ctrl_model i_ctrl (.clk_i(clk), .single_i(single), .dq_i(dq), .k_o(k),
        .kb_o(kb), .c_o(c), .cb_o(cb), .load_n_o(load_n), .dir_o(dir), .addr_o(addr),
        .bl_o(bl), .sel_n_o(sel_n), .dq_o(ctl_dq), .dq_oe_o(ctl_oe));
    bsp_port i_dut (.clk_i(clk), .sys_rst_i(sys_rst), .main_input_timing_pos_i(k),
        .main_input_timing_neg_i(kb), .output_timing_pos_i(c), .output_timing_neg_i(cb),
        .single_clock_mode_i(single), .width_sel_i(width), .load_n_i(load_n),
        .access_dir_i(dir), .word_addr_i(addr), .burst_lsb_addr_i(bl),
        .byte_lane_write_sel_n_i(sel_n), .data_pins_i(dq), .data_pins_o(dut_dq),
        .data_pins_oe_o(dut_oe), .drain_stall_i(stall), .wr_buf_ready_o(rdy));
    task automatic chk(input string nm, input logic [35:0] exp, input logic [35:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic b, input logic [35:0] w0,
        input logic [35:0] w1, input logic [3:0] s0, input logic [3:0] s1);
        logic [35:0] r0;
        logic [35:0] r1;
        i_ctrl.xfer(1'b0, a, b, w0, w1, s0, s1, r0, r1);
        // a stale read taken without load would drive after this launch edge
        @(posedge k);
        repeat (5) @(negedge clk);
        chk("oe_after_write", 36'h0, {35'h0, dut_oe});
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic b, input logic [35:0] e0,
        input logic [35:0] e1);
        logic [35:0] r0;
        logic [35:0] r1;
        i_ctrl.xfer(1'b1, a, b, 36'h0, 36'h0, 4'h0, 4'h0, r0, r1);
        chk("rd_word0", e0, r0);
        chk("rd_word1", e1, r1);
        @(posedge k);
        repeat (5) @(negedge clk);
        chk("oe_idle", 36'h0, {35'h0, dut_oe});
    endtask
    task automatic t_reset();
        chk("oe_rst", 36'h0, {35'h0, dut_oe});
        chk("rdy_rst", 36'h1, {35'h0, rdy});
        chk("dq_rst", 36'h0, dut_dq);
    endtask
    task automatic t_x36();
        wr(3'h5, 1'b0, W0, W1, 4'h0, 4'h0);
        rd_chk(3'h5, 1'b0, W0, W1);
        rd_chk(3'h5, 1'b1, W1, W0);
    endtask
    task automatic t_lanes();
        wr(3'h5, 1'b0, 36'ha_aaaa_aaaa, 36'h5_5555_5555, 4'ha, 4'h5);
        rd_chk(3'h5, 1'b0, E0, E1);
    endtask
    task automatic t_single();
        single = 1'b1;
        rd_chk(3'h5, 1'b1, E1, E0);
        single = 1'b0;
    endtask
    task automatic t_x8();
        width = 2'h0;
        wr(3'h2, 1'b1, W0, W1, 4'h0, 4'h0);
        rd_chk(3'h2, 1'b0, W0 & 36'hff, W1 & 36'hff);
        width = 2'h3;
    endtask
    task automatic t_x9();
        width = 2'h1;
        wr(3'h6, 1'b1, W0, W1, 4'he, 4'he);
        rd_chk(3'h6, 1'b0, W0 & 36'h0_0000_01ff, W1 & 36'h0_0000_01ff);
        width = 2'h3;
    endtask
    task automatic t_x18();
        width = 2'h2;
        wr(3'h3, 1'b1, W0, W1, 4'h0, 4'h0);
        rd_chk(3'h3, 1'b1, W0 & 36'h0_0003_ffff, W1 & 36'h0_0003_ffff);
        width = 2'h3;
    endtask
    task automatic t_stall();
        stall = 1'b1;
        wr(3'h1, 1'b0, W1, W0, 4'h0, 4'h0);
        chk("buf_full", 36'h0, {35'h0, rdy});
        wr(3'h5, 1'b0, W1, W1, 4'h0, 4'h0);
        stall = 1'b0;
        repeat (6) @(negedge clk);
        chk("buf_drained", 36'h1, {35'h0, rdy});
        rd_chk(3'h1, 1'b0, W1, W0);
        rd_chk(3'h5, 1'b0, E0, E1);
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (8) @(negedge clk);
        t_reset();
        t_x36();
        t_lanes();
        t_single();
        t_x8();
        t_x9();
        t_x18();
        t_stall();
        finish_test();
    end
    // run needs about 5.3 us; cut a hang well beyond that
    initial begin
        #50000;
        n_fail++;
        finish_test();
    end
endmodule
